// [hdl/tcr_consts.svh]
/*
 * Register map, field positions, reset values and bus answers of the
 * two-timer control and readout block.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH

// per-timer window: second timer sits one stride above the first
`define TCR_TMR_STRIDE   8'h20
`define TCR_TMR_SEL_BIT  5
`define TCR_OFF_SC       8'h00
`define TCR_OFF_CNTH     8'h04
`define TCR_OFF_CNTL     8'h08
`define TCR_OFF_MOD      8'h0C
`define TCR_OFF_CAP      8'h10
`define TCR_OFF_ISTAT    8'h40
`define TCR_OFF_IMASK    8'h44

// status and control byte
`define TCR_SC_OVF       7
`define TCR_SC_IE        6
`define TCR_SC_HALT      5
`define TCR_SC_CLR       4
`define TCR_SC_PRESC_LO  0

`define TCR_PRESC_EXT    3'h7
`define TCR_MOD_RST      16'hFFFF
`define TCR_HALT_RST     1'b1
`define TCR_MASK_RST     2'h0

`define TCR_RESP_OKAY    2'h0
`define TCR_RESP_SLVERR  2'h2

`endif

// [hdl/tcr_pkg.sv]
/*
 * Types shared by the timer control and readout block.
 * Assumes tcr_consts.svh is on the include path.
 */
`include "tcr_consts.svh"

package tcr_pkg;

    typedef enum logic [2:0] {
        TCR_REG_SC,
        TCR_REG_CNTH,
        TCR_REG_CNTL,
        TCR_REG_MOD,
        TCR_REG_CAP,
        TCR_REG_ISTAT,
        TCR_REG_IMASK,
        TCR_REG_NONE
    } tcr_reg_t;

    typedef struct packed {
        logic             awready;
        logic             wready;
        logic             aw_have;
        logic             w_have;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic [7:0]       raddr;
        logic [1:0][15:0] cnt;
        logic [1:0][5:0]  pre;
        logic [1:0]       halt;
        logic [1:0]       ovf_ie;
        logic [1:0]       ovf;
        logic [1:0]       ovf_armed;
        logic [1:0][2:0]  prescale_select;
        logic [1:0][15:0] modv;
        logic [1:0][7:0]  lat_buf;
        logic [1:0]       latched;
        logic [1:0]       ext_prev;
        logic [1:0][15:0] cap_val;
        logic [1:0]       cap_strobe;
        logic [1:0]       tirq;
        logic [1:0]       ev_stat;
        logic [1:0]       ev_mask;
        logic             irq;
    } tcr_state_t;

endpackage

// [hdl/tcr_top.sv]
/*
 * Two 16-bit timers: control bits, prescaler, counter with modulo,
 * byte-wise readout with low-byte latch, capture gating, interrupts,
 * all behind an AXI4-Lite slave.
 * Assumes every input is synchronous to clk, including the external
 * timer clocks and the capture requests from the channel logic.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tcr_consts.svh"

module tcr_top #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [1:0]        timer_external_clock,
    input  wire logic [1:0]        capture_request,
    output logic [1:0]             capture_strobe,
    output logic [1:0]             overflow_irq,
    output logic                   irq
);
    import tcr_pkg::*;

    tcr_state_t s_ff;
    tcr_state_t nxt_s;

    // assertion helpers, driven alongside the next state
    logic [1:0] wr_clr;
    logic [1:0] wr_halt;
    logic [1:0] rd_low;
    logic [1:0] rd_high;
    logic [1:0] ovf_ev;

    function automatic tcr_reg_t decode(input logic [7:0] a);
        logic [7:0] off;
        off = a & (`TCR_TMR_STRIDE - 8'h01);
        decode = TCR_REG_NONE;
        if (a == `TCR_OFF_ISTAT) begin
            decode = TCR_REG_ISTAT;
        end else if (a == `TCR_OFF_IMASK) begin
            decode = TCR_REG_IMASK;
        end else if (a < (`TCR_TMR_STRIDE << 1)) begin
            unique case (off)
                `TCR_OFF_SC:   decode = TCR_REG_SC;
                `TCR_OFF_CNTH: decode = TCR_REG_CNTH;
                `TCR_OFF_CNTL: decode = TCR_REG_CNTL;
                `TCR_OFF_MOD:  decode = TCR_REG_MOD;
                `TCR_OFF_CAP:  decode = TCR_REG_CAP;
                default:       decode = TCR_REG_NONE;
            endcase
        end
    endfunction

    // low bits of the prescaler that must all be ones for a tick
    function automatic logic [5:0] pre_mask(input logic [2:0] sel);
        pre_mask = 6'(({6'h00, 1'b1} << sel) - 7'h01);
    endfunction

    always_comb begin
        tcr_reg_t   wk;
        tcr_reg_t   rk;
        logic       wi;
        logic       ri;
        logic       do_wr;
        logic       tick;
        logic [7:0] sc;
        nxt_s   = s_ff;
        wr_clr  = 2'h0;
        wr_halt = 2'h0;
        rd_low  = 2'h0;
        rd_high = 2'h0;
        ovf_ev  = 2'h0;
        wk      = decode(s_ff.awaddr);
        wi      = s_ff.awaddr[`TCR_TMR_SEL_BIT];
        rk      = decode(8'(s_axi_araddr));
        ri      = s_axi_araddr[`TCR_TMR_SEL_BIT];
        // a write waits while the previous response is still unclaimed
        do_wr   = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;
        tick    = 1'b0;
        sc      = 8'h00;

        // write channel: address and data taken in either order
        if (s_ff.awready && s_axi_awvalid) begin
            nxt_s.aw_have = 1'b1;
            nxt_s.awaddr  = 8'(s_axi_awaddr);
        end
        if (s_ff.wready && s_axi_wvalid) begin
            nxt_s.w_have = 1'b1;
            nxt_s.wdata  = s_axi_wdata;
            nxt_s.wstrb  = s_axi_wstrb;
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (do_wr) begin
            nxt_s.aw_have = 1'b0;
            nxt_s.w_have  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = (wk == TCR_REG_NONE) ? `TCR_RESP_SLVERR
                                                 : `TCR_RESP_OKAY;
            if (wk == TCR_REG_SC && s_ff.wstrb[0]) begin
                nxt_s.ovf_ie[wi]    = s_ff.wdata[`TCR_SC_IE];
                nxt_s.halt[wi]      = s_ff.wdata[`TCR_SC_HALT];
                nxt_s.prescale_select[wi] = s_ff.wdata[`TCR_SC_PRESC_LO +: 3];
                wr_clr[wi]          = s_ff.wdata[`TCR_SC_CLR];
                wr_halt[wi]         = s_ff.wdata[`TCR_SC_HALT];
                // writing 1 to the flag does nothing; 0 clears once armed
                if (!s_ff.wdata[`TCR_SC_OVF] && s_ff.ovf_armed[wi]) begin
                    nxt_s.ovf[wi] = 1'b0;
                end
                nxt_s.ovf_armed[wi] = 1'b0;
            end
            if (wk == TCR_REG_MOD) begin
                if (s_ff.wstrb[0]) begin
                    nxt_s.modv[wi][7:0] = s_ff.wdata[7:0];
                end
                if (s_ff.wstrb[1]) begin
                    nxt_s.modv[wi][15:8] = s_ff.wdata[15:8];
                end
            end
            if (wk == TCR_REG_IMASK && s_ff.wstrb[0]) begin
                nxt_s.ev_mask = s_ff.wdata[1:0];
            end
            // count bytes and capture value ignore writes
        end
        nxt_s.awready = !nxt_s.aw_have;
        nxt_s.wready  = !nxt_s.w_have;

        // read channel; read side effects happen on acceptance
        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (s_ff.arready && s_axi_arvalid) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.raddr  = 8'(s_axi_araddr);
            nxt_s.rresp  = (rk == TCR_REG_NONE) ? `TCR_RESP_SLVERR
                                                : `TCR_RESP_OKAY;
            nxt_s.rdata  = 32'h0000_0000;
            unique case (rk)
                TCR_REG_SC: begin
                    sc[`TCR_SC_OVF]        = s_ff.ovf[ri];
                    sc[`TCR_SC_IE]         = s_ff.ovf_ie[ri];
                    sc[`TCR_SC_HALT]       = s_ff.halt[ri];
                    sc[`TCR_SC_PRESC_LO +: 3] = s_ff.prescale_select[ri];
                    nxt_s.rdata[7:0]       = sc;
                    if (s_ff.ovf[ri]) begin
                        nxt_s.ovf_armed[ri] = 1'b1;
                    end
                end
                TCR_REG_CNTH: begin
                    rd_high[ri]      = 1'b1;
                    nxt_s.rdata[7:0] = s_ff.cnt[ri][15:8];
                    if (!s_ff.latched[ri]) begin
                        nxt_s.lat_buf[ri] = s_ff.cnt[ri][7:0];
                        nxt_s.latched[ri] = 1'b1;
                    end
                end
                TCR_REG_CNTL: begin
                    rd_low[ri] = 1'b1;
                    // held value survives until this read or a clear of the counter
                    nxt_s.rdata[7:0] = s_ff.latched[ri] ? s_ff.lat_buf[ri]
                                                        : s_ff.cnt[ri][7:0];
                    nxt_s.latched[ri] = 1'b0;
                end
                TCR_REG_MOD: nxt_s.rdata[15:0] = s_ff.modv[ri];
                TCR_REG_CAP: nxt_s.rdata[15:0] = s_ff.cap_val[ri];
                TCR_REG_ISTAT: begin
                    nxt_s.rdata[1:0] = s_ff.ev_stat;
                    nxt_s.ev_stat    = 2'h0;
                end
                TCR_REG_IMASK: nxt_s.rdata[1:0] = s_ff.ev_mask;
                TCR_REG_NONE:  nxt_s.rdata = 32'h0000_0000;
            endcase
        end
        nxt_s.arready = !nxt_s.rvalid;

        // the two timers are identical
        for (int i = 0; i < 2; i++) begin
            // external clock counts on its rising edge; it idles low
            nxt_s.ext_prev[i] = timer_external_clock[i];
            if (s_ff.prescale_select[i] == `TCR_PRESC_EXT) begin
                tick = timer_external_clock[i] && !s_ff.ext_prev[i];
            end else begin
                tick = (s_ff.pre[i] & pre_mask(s_ff.prescale_select[i]))
                       == pre_mask(s_ff.prescale_select[i]);
            end
            if (wr_clr[i]) begin
                // counter, prescaler and readout latch go to zero
                nxt_s.cnt[i]     = 16'h0000;
                nxt_s.pre[i]     = 6'h00;
                nxt_s.lat_buf[i] = 8'h00;
                nxt_s.latched[i] = 1'b0;
            end else if (!s_ff.halt[i]) begin
                // prescaler frozen with the counter, so a halt keeps phase
                nxt_s.pre[i] = s_ff.pre[i] + 6'h01;
                if (tick) begin
                    if (s_ff.cnt[i] == s_ff.modv[i]) begin
                        nxt_s.cnt[i] = 16'h0000;
                        ovf_ev[i]    = 1'b1;
                    end else begin
                        nxt_s.cnt[i] = s_ff.cnt[i] + 16'h0001;
                    end
                end
            end
            // a new overflow beats a clear in the same cycle
            if (ovf_ev[i]) begin
                nxt_s.ovf[i]       = 1'b1;
                nxt_s.ovf_armed[i] = 1'b0;
                nxt_s.ev_stat[i]   = 1'b1;
            end
            nxt_s.cap_strobe[i] = capture_request[i] && !s_ff.halt[i];
            if (nxt_s.cap_strobe[i]) begin
                nxt_s.cap_val[i] = s_ff.cnt[i];
            end
            nxt_s.tirq[i] = nxt_s.ovf[i] && nxt_s.ovf_ie[i];
        end
        nxt_s.irq = |(nxt_s.ev_stat & nxt_s.ev_mask);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_ff         <= '0;
            s_ff.halt    <= {2{`TCR_HALT_RST}};
            s_ff.modv    <= {2{`TCR_MOD_RST}};
            s_ff.ev_mask <= `TCR_MASK_RST;
            // counter bytes and latch take zero with the rest
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready  = s_ff.awready;
    assign s_axi_wready   = s_ff.wready;
    assign s_axi_bvalid   = s_ff.bvalid;
    assign s_axi_bresp    = s_ff.bresp;
    assign s_axi_arready  = s_ff.arready;
    assign s_axi_rvalid   = s_ff.rvalid;
    assign s_axi_rdata    = s_ff.rdata;
    assign s_axi_rresp    = s_ff.rresp;
    assign capture_strobe = s_ff.cap_strobe;
    assign overflow_irq   = s_ff.tirq;
    assign irq            = s_ff.irq;

    a_reset_halt_set: assert property (
        @(posedge clk) $rose(reset_n) |-> s_ff.halt == 2'h3)
        else $error("halt bits not set after reset");

    a_halt_freezes_count: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s_ff.halt[0] && !wr_clr[0]) |=> $stable(s_ff.cnt[0]))
        else $error("counter moved while halted");

    a_capture_gated: assert property (
        @(posedge clk) disable iff (!reset_n)
        capture_strobe[1] |-> !$past(s_ff.halt[1]))
        else $error("capture passed while halted");

    a_clear_zeroes: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_clr[0] |=> (s_ff.cnt[0] == 16'h0000 && s_ff.pre[0] == 6'h00))
        else $error("clear did not zero counter and prescaler");

    a_clear_reads_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s_ff.rvalid && s_ff.raddr == `TCR_OFF_SC) |-> !s_ff.rdata[4])
        else $error("clear bit read back as one");

    a_halt_clear_stops: assert property (
        @(posedge clk) disable iff (!reset_n)
        (wr_clr[0] && wr_halt[0]) |=> (s_ff.cnt[0] == 16'h0000) [*3])
        else $error("halt with clear did not stop at zero");

    a_latch_holds: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s_ff.latched[0] && !rd_low[0] && !wr_clr[0])
        |=> (s_ff.latched[0] && $stable(s_ff.lat_buf[0])))
        else $error("latched low byte changed without a low read");

    a_flag_set_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        ovf_ev[0] |=> (s_ff.ovf[0] && s_ff.ev_stat[0]))
        else $error("overflow event lost");

    a_ovf_irq_level: assert property (
        @(posedge clk) disable iff (!reset_n)
        overflow_irq[0] == (s_ff.ovf[0] && s_ff.ovf_ie[0]))
        else $error("overflow request does not follow flag and enable");

    a_ovf_irq_disabled: assert property (
        @(posedge clk) disable iff (!reset_n)
        !s_ff.ovf_ie[1] |-> !overflow_irq[1])
        else $error("overflow request while disabled");

    a_high_read_latches: assert property (
        @(posedge clk) disable iff (!reset_n)
        (rd_high[0] && !s_ff.latched[0] && !wr_clr[0])
        |=> (s_ff.latched[0]
             && s_ff.lat_buf[0] == $past(s_ff.cnt[0][7:0])))
        else $error("high byte read did not latch the low byte");

    a_clear_drops_latch: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_clr[0] |=> (!s_ff.latched[0] && s_ff.lat_buf[0] == 8'h00))
        else $error("clear left a latched low byte");

endmodule
`default_nettype wire

// [sim/tb_top.sv]
/*
 * Self-checking bench for the two-timer control and readout block.
 * Assumes tcr_top with its default address width and the byte map of
 * tcr_consts.svh; the bench is the only AXI4-Lite master.
 */
`timescale 1ns/1ns
`default_nettype none
`include "tcr_consts.svh"

module tb_top;
    typedef struct {
        logic [31:0] lo;
        logic [31:0] hi;
        logic [1:0]  resp;
    } tcr_exp_t;

    localparam int RUN_CYC = 200;

    logic        clk;
    logic        reset_n;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  ext_clk;
    logic [1:0]  cap_req;
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic [1:0]  cap_strobe;
    logic [1:0]  ovf_irq;
    logic        irq;
    logic [15:0] rnd;
    tcr_exp_t    exp_r[$];
    logic [1:0]  exp_b[$];
    tcr_exp_t    mon_e;
    int          n_errors;
    int          total_checks;
    int          n_strobe;

    tcr_top dut (
        .clk                  (clk),
        .reset_n              (reset_n),
        .s_axi_awaddr         (awaddr),
        .s_axi_awvalid        (awvalid),
        .s_axi_awready        (awready),
        .s_axi_wdata          (wdata),
        .s_axi_wstrb          (wstrb),
        .s_axi_wvalid         (wvalid),
        .s_axi_wready         (wready),
        .s_axi_bresp          (bresp),
        .s_axi_bvalid         (bvalid),
        .s_axi_bready         (bready),
        .s_axi_araddr         (araddr),
        .s_axi_arvalid        (arvalid),
        .s_axi_arready        (arready),
        .s_axi_rdata          (rdata),
        .s_axi_rresp          (rresp),
        .s_axi_rvalid         (rvalid),
        .s_axi_rready         (rready),
        .timer_external_clock (ext_clk),
        .capture_request      (cap_req),
        .capture_strobe       (cap_strobe),
        .overflow_irq         (ovf_irq),
        .irq                  (irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // range compare; an unknown never satisfies it
    task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                       input logic [31:0] hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h..%h",
                     $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] resp);
        @(posedge clk);
        exp_b.push_back(resp);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] lo,
                      input logic [31:0] hi, input logic [1:0] resp);
        @(posedge clk);
        exp_r.push_back('{lo, hi, resp});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic rx(input logic [7:0] a, input logic [31:0] v);
        rd(a, v, v, `TCR_RESP_OKAY);
    endtask

    task automatic wx(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, `TCR_RESP_OKAY);
    endtask

    // one count per rising edge; the line idles low between pulses
    task automatic tick(input int tm, input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clk[tm] <= 1'b1;
            @(posedge clk);
            ext_clk[tm] <= 1'b0;
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic cap(input int tm);
        @(posedge clk);
        cap_req[tm] <= 1'b1;
        @(posedge clk);
        cap_req[tm] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // results are matched against the oldest note as they appear
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready && exp_r.size() > 0) begin
            mon_e = exp_r.pop_front();
            chk(rdata, mon_e.lo, mon_e.hi);
            chk({30'h0000_0000, rresp}, {30'h0, mon_e.resp},
                {30'h0, mon_e.resp});
        end
        if (bvalid === 1'b1 && bready && exp_b.size() > 0) begin
            mon_e.resp = exp_b.pop_front();
            chk({30'h0000_0000, bresp}, {30'h0, mon_e.resp},
                {30'h0, mon_e.resp});
        end
        if (cap_strobe[0] === 1'b1) n_strobe++;
        if (cap_strobe[1] === 1'b1) n_strobe++;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        ext_clk = 2'h0;
        cap_req = 2'h0;
        rnd = 16'h9EB4;
        n_errors = 0;
        total_checks = 0;
        n_strobe = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rx(8'h00, 32'h0000_0020);
        rx(8'h20, 32'h0000_0020);
        rx(8'h04, 32'h0000_0000);
        rx(8'h08, 32'h0000_0000);
        rx(8'h0C, 32'h0000_FFFF);
        // 0x34 falls in the gap above the capture register
        rd(8'h34, 32'h0, 32'h0, `TCR_RESP_SLVERR);
        wr(8'h34, 32'h0000_00FF, `TCR_RESP_SLVERR);
        for (int k = 0; k < 7; k++) begin
            wx(8'h00, 32'h0000_0030);
            rx(8'h08, 32'h0000_0000);
            wx(8'h00, k);
            repeat (RUN_CYC) @(posedge clk);
            wx(8'h00, 32'h0000_0020 | k);
            rd(8'h08, (RUN_CYC - 4) >> k, ((RUN_CYC + 8) >> k) + 1,
               `TCR_RESP_OKAY);
            rx(8'h00, 32'h0000_0020 | k);
        end
        wx(8'h00, 32'h0000_0037);
        tick(0, 3);
        rx(8'h08, 32'h0000_0000);
        wx(8'h00, 32'h0000_0007);
        tick(0, 5);
        rx(8'h04, 32'h0000_0000);
        tick(0, 3);
        rx(8'h04, 32'h0000_0000);
        rx(8'h08, 32'h0000_0005);
        rx(8'h08, 32'h0000_0008);
        rnd = lfsr_next(rnd);
        wx(8'h04, {16'h0000, rnd});
        rnd = lfsr_next(rnd);
        wx(8'h08, {16'h0000, rnd});
        rx(8'h08, 32'h0000_0008);
        wx(8'h00, 32'h0000_0027);
        tick(0, 2);
        rx(8'h08, 32'h0000_0008);
        wx(8'h00, 32'h0000_0007);
        tick(0, 2);
        rx(8'h08, 32'h0000_000A);
        rx(8'h04, 32'h0000_0000);
        wx(8'h00, 32'h0000_0017);
        rx(8'h08, 32'h0000_0000);
        rnd = lfsr_next(rnd);
        tick(0, rnd[3:0] + 1);
        rx(8'h08, {28'h000_0000, rnd[3:0]} + 32'h0000_0001);
        rx(8'h00, 32'h0000_0007);
        wx(8'h20, 32'h0000_0007);
        tick(1, 4);
        rx(8'h24, 32'h0000_0000);
        rx(8'h28, 32'h0000_0004);
        rx(8'h08, {28'h000_0000, rnd[3:0]} + 32'h0000_0001);
        wx(8'h0C, 32'h0000_0003);
        wx(8'h00, 32'h0000_0017);
        tick(0, 4);
        chk({30'h0, ovf_irq}, 32'h0, 32'h0);
        chk({31'h0, irq}, 32'h0, 32'h0);
        rx(8'h00, 32'h0000_0087);
        wx(8'h00, 32'h0000_00C7);
        repeat (3) @(posedge clk);
        chk({30'h0, ovf_irq}, 32'h1, 32'h1);
        wx(8'h44, 32'h0000_0001);
        rx(8'h44, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        rx(8'h40, 32'h0000_0001);
        rx(8'h40, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0, 32'h0);
        wx(8'h00, 32'h0000_00E7);
        wx(8'h00, 32'h0000_00C7);
        rx(8'h00, 32'h0000_00C7);
        wx(8'h00, 32'h0000_0047);
        wx(8'h00, 32'h0000_0067);
        rx(8'h00, 32'h0000_0067);
        chk({30'h0, ovf_irq}, 32'h0, 32'h0);
        cap(0);
        chk(n_strobe, 32'h0, 32'h0);
        wx(8'h00, 32'h0000_0047);
        cap(0);
        chk(n_strobe, 32'h1, 32'h1);
        cap(1);
        chk(n_strobe, 32'h2, 32'h2);
        rx(8'h30, 32'h0000_0004);
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
